// ==== rtl/flash_cmd_pkg.sv ====
// Constants, types and state layout for the serial flash command block.
// Assumes one 100 MHz system clock; link pins are asynchronous to it.
package flash_cmd_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 700000;
  localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam logic [31:0] PAGE_BYTES = 32'h0000_0100;

  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_STATUS_LO = 8'h05;
  localparam logic [7:0] OP_STATUS_HI = 8'h35;
  localparam logic [7:0] OP_QUAD_READ = 8'hEB;
  localparam logic [7:0] OP_QUAD_WORD_READ = 8'hE7;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_CONT_RESET = 8'hFF;
  localparam logic [3:0] CONT_NIBBLE = 4'hA;

  // Last edge count of each phase, and the wrap setting loaded at reset
  localparam logic [5:0] OPC_LAST = 6'h07;
  localparam logic [5:0] QADDR_LAST = 6'h05;
  localparam logic [5:0] QMODE_LAST = 6'h01;
  localparam logic [5:0] QDUMMY_LAST = 6'h03;
  localparam logic [5:0] WDUMMY_LAST = 6'h01;
  localparam logic [5:0] WRAP_LAST = 6'h1F;
  localparam logic [5:0] PPADDR_LAST = 6'h17;
  localparam logic [2:0] WRAP_RESET = 3'h1;

  // Register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MEM_ADDR = 4'h8;
  localparam logic [3:0] REG_MEM_DATA = 4'hC;
  localparam int CTRL_QE_BIT = 0;
  localparam int CTRL_BP_LSB = 8;
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam int STAT_WRAP_LSB = 4;
  localparam int STAT_CONT_BIT = 8;

  typedef logic [9:0] mem_addr_type;

  typedef enum logic [3:0] {
    PH_IDLE = 4'h0, PH_OPCODE = 4'h1, PH_QADDR = 4'h2, PH_QMODE = 4'h3,
    PH_QDUMMY = 4'h4, PH_QDATA = 4'h5, PH_STATUS = 4'h6, PH_WRAP = 4'h7,
    PH_WRAPEND = 4'h8, PH_PPADDR = 4'h9, PH_PPDATA = 4'hA, PH_IGNORE = 4'hB
  } phase_type;

  typedef struct packed {
    logic chip_sel_n;
    logic serial_clk;
    logic [3:0] quad_io_line;
  } link_in_type;

  typedef struct packed {
    logic [3:0] quad_io_line;
    logic [3:0] quad_io_line_oe_n;
  } link_out_type;

  typedef struct packed {
    logic cs_s1, cs_s2, clk_s1, clk_s2, clk_s3;
    logic [3:0] io_s1, io_s2;
    phase_type ph;
    logic [5:0] cnt;
    logic [7:0] opc;
    logic [23:0] sh;
    logic [7:0] mode;
    mem_addr_type addr;
    logic half;
    logic [7:0] obyte;
    logic [2:0] obit;
    logic word_rd, cont, cont_word;
    logic quad_enable_bit;
    logic [4:0] block_protect_bits;
    logic write_latch, write_in_progress;
    logic [2:0] wrap_setting_bits;
    logic [31:0] tmr;
    logic [1:0] pp_page;
    logic pp_any;
    logic [255:0] pvalid;
    mem_addr_type maddr;
    logic waitreq;
    logic [31:0] rdata;
    logic [3:0] io_out, io_oe_n;
  } state_type;

endpackage

// ==== rtl/quad_flash_cmd.sv ====
// Serial flash command logic: quad reads with wrap, wrap setup, page program.
// Assumes an SPI host on the link pins and an Avalon-MM master on the bus.
//
// What this block does
// RULE_01: Quad read takes address, mode byte, four dummy clocks, four bits per edge.
// RULE_02: After dummy clocks, read data leaves four bits per clock on the IO lines.
// RULE_03: Reads start anywhere and step the address by one per byte.
// RULE_04: Quad reads run only with the quad enable bit set.
// RULE_05: Mode byte A_ lets the next select-low start straight at the address.
// RULE_06: Any other mode byte ends continuous mode; next transaction needs an opcode.
// RULE_07: The continuous-read reset command clears the stored mode bits.
// RULE_08: Word quad read matches quad read but with two dummy clocks.
// RULE_09: Host gives the word quad read an even address.
// RULE_10: Word quad read honours continuous mode the same way.
// RULE_11: With wrap on, reads loop inside the selected section of the page.
// RULE_12: Stored wrap setting applies to all later quad reads until changed.
// RULE_13: Wrap command is opcode, 24 dummy bits, 8 setting bits, then select high.
// RULE_14: Wrap-disable bit low wraps; high, the default, reads linearly.
// RULE_15: Wrap length field picks 8, 16, 32 or 64 byte sections.
// RULE_16: Host sets wrap-disable again to return to linear reads.
// RULE_17: Page program needs the write latch set by write enable.
// RULE_18: Host keeps select low and sends opcode, three address bytes, data.
// RULE_19: Program data past the page end restarts at the page start.
// RULE_20: Only the last 256 bytes are kept; untouched page bytes stay.
// RULE_21: Program runs only if select rises on a data byte boundary.
// RULE_22: Select rise starts a timed program; busy set, latch cleared, status readable.
// RULE_23: Program into a protected page is ignored.
// RULE_24: Write enable sets the write latch.
// RULE_25: Status opcodes return the high or low status byte.
// RULE_26: Reads during a busy cycle are rejected without disturbing it.
// RULE_27: Only the upper mode nibble decides continuous mode.
// RULE_28: Host releases the IO lines before the device drives read data.
`timescale 1ns/10ps
module quad_flash_cmd import flash_cmd_pkg::*; #(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire link_in_type link_in,
  output link_out_type link_out,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  state_type q, d;
  logic [7:0] mem [1024];
  logic [7:0] pbuf [256];
  logic mem_we, pb_we, prog_we;
  mem_addr_type mem_waddr;
  logic [7:0] mem_wdata, pb_data, pb_idx, rd_byte, av_byte, pb_rd, st_lo, st_hi, op_full;
  logic [23:0] sh_nib, sh_bit;
  logic rise, fall, pp_go, wrap_go, wel_go, adv, mode_done, read_go;

  function automatic mem_addr_type wrap_mask(input logic [1:0] sel);
    case (sel)
      2'h0: return 10'h007;
      2'h1: return 10'h00F;
      2'h2: return 10'h01F;
      default: return 10'h03F;
    endcase
  endfunction

  function automatic mem_addr_type next_addr(input mem_addr_type a, input logic [2:0] w);
    mem_addr_type m;
    m = wrap_mask(w[2:1]);
    if (w[0]) begin
      return a + 10'h001;
    end
    return (a & ~m) | ((a + 10'h001) & m);
  endfunction

  function automatic logic page_protected(input logic [4:0] bp, input logic [1:0] page);
    case (bp[2:0])
      3'h0: return 1'h0;
      3'h1: return page == 2'h3;
      3'h2: return page[1];
      default: return 1'h1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Arrays: flash contents and page program buffer

  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (pb_we) begin
      pbuf[pb_idx] <= pb_data;
    end
  end

  assign rd_byte = mem[q.addr];
  assign av_byte = mem[q.maddr];
  assign pb_rd = pbuf[q.tmr[7:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    rise = q.clk_s2 & ~q.clk_s3;
    fall = ~q.clk_s2 & q.clk_s3;
    op_full = {q.opc[6:0], q.io_s2[0]};
    sh_nib = {q.sh[19:0], q.io_s2};
    sh_bit = {q.sh[22:0], q.io_s2[0]};
    st_lo = {1'h0, q.block_protect_bits, q.write_latch, q.write_in_progress};
    st_hi = {6'h00, q.quad_enable_bit, 1'h0};
    mem_we = 1'h0;
    mem_waddr = q.maddr;
    mem_wdata = 8'h00;
    pb_we = 1'h0;
    pb_idx = 8'h00;
    pb_data = 8'h00;
    prog_we = 1'h0;
    pp_go = 1'h0;
    wrap_go = 1'h0;
    wel_go = 1'h0;
    adv = 1'h0;
    mode_done = 1'h0;
    read_go = 1'h0;
    // Two flip-flops on every pin before any use
    d.cs_s1 = link_in.chip_sel_n;
    d.cs_s2 = q.cs_s1;
    d.clk_s1 = link_in.serial_clk;
    d.clk_s2 = q.clk_s1;
    d.clk_s3 = q.clk_s2;
    d.io_s1 = link_in.quad_io_line;
    d.io_s2 = q.io_s1;

    // Self-timed program: buffer is copied in the first 256 cycles
    if (q.write_in_progress) begin
      d.tmr = q.tmr + 32'h1;
      if (q.tmr < PAGE_BYTES && q.pvalid[q.tmr[7:0]]) begin
        prog_we = 1'h1; // see RULE_20
        mem_we = 1'h1;
        mem_waddr = {q.pp_page, q.tmr[7:0]};
        mem_wdata = pb_rd;
      end
      if (q.tmr == 32'(PROG_CYCLES - 1)) begin
        d.write_in_progress = 1'h0; // see RULE_22
      end
    end

    if (q.cs_s2) begin
      d.io_oe_n = 4'hF;
      d.ph = PH_IDLE;
      // Partial bytes or no data byte discard the whole program
      if (q.ph == PH_PPDATA && q.cnt[2:0] == 3'h0 && q.pp_any && q.write_latch && !q.write_in_progress
          && !page_protected(q.block_protect_bits, q.addr[9:8])) begin // see RULE_21, RULE_17, RULE_23
        pp_go = 1'h1;
        d.write_in_progress = 1'h1; // see RULE_22
        d.write_latch = 1'h0;
        d.tmr = 32'h0;
        d.pp_page = q.addr[9:8];
      end
      if (q.ph == PH_WRAPEND) begin
        wrap_go = 1'h1;
        d.wrap_setting_bits = q.sh[6:4]; // see RULE_13, RULE_12
      end
    end else if (q.ph == PH_IDLE) begin
      d.cnt = 6'h00;
      if (q.cont) begin
        // Continuous mode skips the opcode; busy or no quad enable ignores it
        d.ph = (q.quad_enable_bit && !q.write_in_progress) ? PH_QADDR : PH_IGNORE; // see RULE_05, RULE_10
        d.word_rd = q.cont_word;
        read_go = q.quad_enable_bit && !q.write_in_progress;
      end else begin
        d.ph = PH_OPCODE;
      end
    end else if (rise) begin
      d.cnt = q.cnt + 6'h01;
      case (q.ph)
        PH_OPCODE: begin
          d.opc = op_full;
          if (q.cnt == OPC_LAST) begin
            d.cnt = 6'h00;
            d.ph = PH_IGNORE;
            case (op_full)
              OP_WRITE_ENABLE: begin
                if (!q.write_in_progress) begin
                  wel_go = 1'h1;
                  d.write_latch = 1'h1; // see RULE_24
                end
              end
              OP_STATUS_LO: begin
                d.ph = PH_STATUS; // see RULE_25
                d.obyte = st_lo;
                d.obit = 3'h7;
              end
              OP_STATUS_HI: begin
                d.ph = PH_STATUS;
                d.obyte = st_hi;
                d.obit = 3'h7;
              end
              OP_QUAD_READ, OP_QUAD_WORD_READ: begin
                if (q.quad_enable_bit && !q.write_in_progress) begin // see RULE_04, RULE_26
                  d.ph = PH_QADDR;
                  d.word_rd = op_full == OP_QUAD_WORD_READ; // see RULE_08
                  read_go = 1'h1;
                end
              end
              OP_SET_WRAP: begin
                if (!q.write_in_progress) begin
                  d.ph = PH_WRAP;
                end
              end
              OP_PAGE_PROGRAM: begin
                if (!q.write_in_progress) begin
                  d.ph = PH_PPADDR;
                  d.pvalid = '0;
                end
              end
              OP_CONT_RESET: begin
                d.cont = 1'h0; // see RULE_07
              end
              default: begin
                d.ph = PH_IGNORE;
              end
            endcase
          end
        end
        PH_QADDR: begin
          d.sh = sh_nib; // see RULE_01
          if (q.cnt == QADDR_LAST) begin
            d.addr = sh_nib[9:0]; // see RULE_03
            d.ph = PH_QMODE;
            d.cnt = 6'h00;
          end
        end
        PH_QMODE: begin
          d.mode = {q.mode[3:0], q.io_s2};
          if (q.cnt == QMODE_LAST) begin
            mode_done = 1'h1;
            // Low nibble of the mode byte is a don't care
            d.cont = q.mode[3:0] == CONT_NIBBLE; // see RULE_27, RULE_05, RULE_06, RULE_07
            d.cont_word = q.word_rd; // see RULE_10
            d.ph = PH_QDUMMY;
            d.cnt = 6'h00;
          end
        end
        PH_QDUMMY: begin
          if (q.cnt == (q.word_rd ? WDUMMY_LAST : QDUMMY_LAST)) begin // see RULE_01, RULE_08
            d.ph = PH_QDATA;
            d.half = 1'h0;
          end
        end
        PH_WRAP: begin
          d.sh = sh_bit;
          if (q.cnt == WRAP_LAST) begin
            d.ph = PH_WRAPEND; // see RULE_13
          end
        end
        PH_WRAPEND: begin
          d.ph = PH_IGNORE;
        end
        PH_PPADDR: begin
          d.sh = sh_bit;
          if (q.cnt == PPADDR_LAST) begin
            d.addr = sh_bit[9:0];
            d.ph = PH_PPDATA;
            d.cnt = 6'h00;
            d.pp_any = 1'h0;
          end
        end
        PH_PPDATA: begin
          d.opc = op_full;
          d.cnt = {3'h0, q.cnt[2:0] + 3'h1};
          if (q.cnt[2:0] == 3'h7) begin
            // Later bytes overwrite earlier ones at the same page offset
            pb_we = 1'h1; // see RULE_20
            pb_idx = q.addr[7:0];
            pb_data = op_full;
            d.pvalid[q.addr[7:0]] = 1'h1;
            d.addr = {q.addr[9:8], q.addr[7:0] + 8'h01}; // see RULE_19
            d.pp_any = 1'h1;
          end
        end
        default: begin
          d.cnt = q.cnt;
        end
      endcase
    end else if (fall) begin
      case (q.ph)
        PH_QDATA: begin
          // High nibble first; the lines turn only after the dummy clocks
          d.io_out = q.half ? rd_byte[3:0] : rd_byte[7:4]; // see RULE_02, RULE_28
          d.io_oe_n = 4'h0;
          d.half = ~q.half;
          if (q.half) begin
            adv = 1'h1;
            d.addr = next_addr(q.addr, q.wrap_setting_bits); // see RULE_03, RULE_11, RULE_14, RULE_15
          end
        end
        PH_STATUS: begin
          d.io_out = {2'h0, q.obyte[q.obit], 1'h0};
          d.io_oe_n = 4'hD;
          d.obit = q.obit - 3'h1;
          if (q.obit == 3'h0) begin
            d.obyte = (q.opc == OP_STATUS_HI) ? st_hi : st_lo; // see RULE_25, RULE_22
          end
        end
        default: begin
          d.io_out = q.io_out;
        end
      endcase
    end

    // Avalon slave: one wait cycle, then a single accept cycle
    if (q.waitreq) begin
      if (avs_read || avs_write) begin
        d.waitreq = 1'h0;
        case (avs_address)
          REG_CTRL: d.rdata = 32'({q.block_protect_bits, 7'h00, q.quad_enable_bit});
          REG_STATUS: d.rdata = 32'({q.cont, 1'h0, q.wrap_setting_bits, 2'h0, q.write_latch,
                                     q.write_in_progress});
          REG_MEM_ADDR: d.rdata = 32'(q.maddr);
          REG_MEM_DATA: d.rdata = 32'(av_byte);
          default: d.rdata = 32'h0;
        endcase
      end
    end else begin
      d.waitreq = 1'h1;
      if (avs_write) begin
        case (avs_address)
          REG_CTRL: begin
            d.quad_enable_bit = avs_writedata[CTRL_QE_BIT];
            d.block_protect_bits = avs_writedata[CTRL_BP_LSB +: 5];
          end
          REG_MEM_ADDR: d.maddr = avs_writedata[9:0];
          REG_MEM_DATA: begin
            // The program engine wins the array in its copy cycles; a bus write in such a cycle is dropped
            if (!prog_we) begin
              mem_we = 1'h1;
              mem_waddr = q.maddr;
              mem_wdata = avs_writedata[7:0];
            end
            d.maddr = q.maddr + 10'h001;
          end
          default: d.maddr = q.maddr;
        endcase
      end else if (avs_read && avs_address == REG_MEM_DATA) begin
        d.maddr = q.maddr + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      q <= '0;
      q.cs_s1 <= 1'h1;
      q.cs_s2 <= 1'h1;
      q.io_oe_n <= 4'hF;
      q.waitreq <= 1'h1;
      q.wrap_setting_bits <= WRAP_RESET; // see RULE_14
    end else begin
      q <= d;
    end
  end

  assign link_out = '{quad_io_line: q.io_out, quad_io_line_oe_n: q.io_oe_n};
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitreq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_prog_start;
    pp_go |=> (q.write_in_progress && !q.write_latch) [*8];
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("program cycle did not start"); // see RULE_22

  property p_wel_set;
    wel_go |=> q.write_latch;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("write latch not set"); // see RULE_24

  property p_qe_gate;
    read_go |-> q.quad_enable_bit ##1 q.ph == PH_QADDR;
  endproperty
  a_qe_gate: assert property (p_qe_gate) else $error("quad read without quad enable"); // see RULE_04

  property p_busy_reject;
    (q.ph == PH_QADDR && $past(q.ph) != PH_QADDR) |-> !$past(q.write_in_progress);
  endproperty
  a_busy_reject: assert property (p_busy_reject) else $error("read accepted while busy"); // see RULE_26

  property p_wrap_store;
    wrap_go |=> q.wrap_setting_bits == $past(q.sh[6:4]) && q.ph == PH_IDLE;
  endproperty
  a_wrap_store: assert property (p_wrap_store) else $error("wrap bits not stored"); // see RULE_13

  property p_wrap_section;
    adv && !q.wrap_setting_bits[0] |=> q.addr[9:6] == $past(q.addr[9:6]);
  endproperty
  a_wrap_section: assert property (p_wrap_section) else $error("wrap left the section"); // see RULE_11

  property p_cont_enter;
    mode_done && q.mode[3:0] == CONT_NIBBLE |=> q.cont;
  endproperty
  a_cont_enter: assert property (p_cont_enter) else $error("continuous mode not entered"); // see RULE_05

  property p_cont_leave;
    mode_done && q.mode[3:0] != CONT_NIBBLE |=> !q.cont;
  endproperty
  a_cont_leave: assert property (p_cont_leave) else $error("continuous mode not left"); // see RULE_06

  property p_drive_window;
    !q.io_oe_n[0] |-> q.ph == PH_QDATA && !$past(q.cs_s2);
  endproperty
  a_drive_window: assert property (p_drive_window) else $error("data driven outside read"); // see RULE_02

  property p_page_stay;
    pb_we |=> q.addr[9:8] == $past(q.addr[9:8]);
  endproperty
  a_page_stay: assert property (p_page_stay) else $error("program left its page"); // see RULE_19

  c_program: cover property (pp_go);
  c_wrap_set: cover property (wrap_go);
  c_cont_read: cover property (read_go && q.cont);
  c_wrapped_read: cover property (adv && !q.wrap_setting_bits[0]);

endmodule

// ==== dv/spi_host_model.sv ====
// SPI host model: drives select, clock and IO lines in mode 0.
// Assumes the 100 MHz system clock; one link clock is 16 of its cycles.
`timescale 1ns/10ps
module spi_host_model import flash_cmd_pkg::*; (
  input wire logic sys_clk,
  input wire link_out_type link_out,
  output link_in_type link_in
);
  logic cs_n = 1'b1;
  logic sck = 1'b0;
  logic [3:0] val = 4'h0;
  logic [3:0] en = 4'h0;
  logic [3:0] lvl;
  logic [3:0] lvl_q = 4'h0;
  logic [3:0] g;
  // Released lines show the inverse, so stale data never reads as valid
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lvl[i] = !link_out.quad_io_line_oe_n[i] ? link_out.quad_io_line[i] : (en[i] ? val[i] : ~val[i]);
    end
  end
  always @(negedge sys_clk) begin
    lvl_q <= lvl;
  end
  assign link_in = '{chip_sel_n: cs_n, serial_clk: sck, quad_io_line: lvl};
  ////////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One link clock; clock idles low, got is the level at the rise
  task automatic shift(input logic [3:0] v, input logic [3:0] m, output logic [3:0] got);
    @(posedge sys_clk);
    val <= v;
    en <= m;
    wt(7);
    sck <= 1'b1;
    got = lvl_q;
    wt(8);
    sck <= 1'b0;
  endtask
  task automatic open_f();
    @(posedge sys_clk);
    cs_n <= 1'b0;
    wt(4);
  endtask
  task automatic close_f();
    wt(4);
    cs_n <= 1'b1;
    en <= 4'h0;
    wt(8);
  endtask
  // Serial bytes MSB first on line 0; fewer bits end mid-byte
  task automatic tx_ser(input logic [7:0] b, input int nbits = 8);
    for (int i = 7; i > 7 - nbits; i--) shift({3'h0, b[i]}, 4'h1, g);
  endtask
  task automatic rx_ser(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      shift(4'h0, 4'h0, g);
      b[i] = g[1];
    end
  endtask
  task automatic tx_quad(input logic [7:0] b);
    shift(b[7:4], 4'hF, g);
    shift(b[3:0], 4'hF, g);
  endtask
  // Opcode 00 means continuous mode: frame starts at the address
  task automatic qread(input logic [7:0] op, input logic [23:0] a, input logic [7:0] md, input int dum,
                       input int n, output logic [63:0] d);
    logic [3:0] h;
    open_f();
    if (op != 8'h00) tx_ser(op);
    tx_quad(a[23:16]);
    tx_quad(a[15:8]);
    tx_quad(a[7:0]);
    tx_quad(md);
    repeat (dum) shift(4'h0, 4'h0, g);
    for (int k = 0; k < n; k++) begin
      shift(4'h0, 4'h0, h);
      shift(4'h0, 4'h0, g);
      d[63 - 8 * k -: 8] = {h, g};
    end
    close_f();
  endtask
endmodule

// ==== dv/tb.sv ====
// Testbench: host model on the link, Avalon master tasks on the bus.
// Assumes a short program time and a 1 KiB array of four pages.
`timescale 1ns/10ps
module tb import flash_cmd_pkg::*;;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  link_in_type link_in;
  link_out_type link_out;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int error_cnt = 0;
  int cmp_count = 0;
  int drive_cnt = 0;
  int snap;
  logic [7:0] mem [1024];
  logic [31:0] rv;
  logic [63:0] rd;
  logic [7:0] sb;
  quad_flash_cmd #(.PROG_CYCLES(300)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .link_in(link_in),
    .link_out(link_out), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  spi_host_model host_u (.sys_clk(sys_clk), .link_out(link_out), .link_in(link_in));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (link_out.quad_io_line_oe_n !== 4'hF) drive_cnt <= drive_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Holds the request until waitrequest is seen low
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      $display("[ERR] waitrequest expected 0 seen %b", avs_waitrequest);
      complete_run();
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      avs(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rv[0] !== 1'b0 && n < 200);
    if (rv[0] !== 1'b0) begin
      error_cnt++;
      $display("[ERR] busy expected 0 seen %b", rv[0]);
      complete_run();
    end
  endtask
  function automatic int nxt(input int a, input int len);
    return (len == 0) ? (a + 1) % 1024 : (a & ~(len - 1)) | ((a + 1) & (len - 1));
  endfunction
  task automatic rdchk(input int a, input int n, input int len);
    for (int k = 0; k < n; k++) begin
      chk("read byte", {24'h0, mem[a]}, {24'h0, rd[63 - 8 * k -: 8]});
      a = nxt(a, len);
    end
  endtask
  task automatic stchk(input string nm, input int lsb, input logic [2:0] exp);
    avs(1'b0, REG_STATUS, 32'h0);
    chk(nm, {29'h0, exp}, {29'h0, rv[lsb +: 3]});
  endtask
  task automatic memchk(input int a);
    avs(1'b1, REG_MEM_ADDR, a);
    avs(1'b0, REG_MEM_DATA, 32'h0);
    chk("array byte", {24'h0, mem[a]}, {24'h0, rv[7:0]});
  endtask
  task automatic ser(input logic [7:0] op);
    host_u.open_f();
    host_u.tx_ser(op);
    host_u.close_f();
  endtask
  // Program n bytes of pattern k^C3 plus part extra bits
  task automatic pp(input logic [23:0] a, input int n, input int part);
    host_u.open_f();
    host_u.tx_ser(OP_PAGE_PROGRAM);
    for (int i = 2; i >= 0; i--) host_u.tx_ser(a[8 * i +: 8]);
    for (int k = 0; k < n; k++) host_u.tx_ser(8'(k) ^ 8'hC3);
    if (part > 0) host_u.tx_ser(8'hFF, part);
    host_u.close_f();
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_reset();
    avs(1'b0, REG_STATUS, 32'h0);
    chk("status reset", 32'h0000_0010, rv);
    avs(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rv);
    avs(1'b1, REG_MEM_ADDR, 32'h0);
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
      avs(1'b1, REG_MEM_DATA, {24'h0, mem[i]});
    end
  endtask
  task automatic s_reads();
    snap = drive_cnt;
    host_u.qread(OP_QUAD_READ, 24'h10, 8'h00, 4, 1, rd);
    chk("no drive", snap, drive_cnt);
    avs(1'b1, REG_CTRL, 32'h1);
    host_u.qread(OP_QUAD_READ, 24'hFE, 8'hA5, 4, 4, rd);
    rdchk(32'hFE, 4, 0);
    stchk("cont on", 8, 3'h1);
    host_u.qread(8'h00, 24'h300, 8'h5F, 4, 2, rd);
    rdchk(32'h300, 2, 0);
    stchk("cont off", 8, 3'h0);
    host_u.qread(OP_QUAD_WORD_READ, 24'h102, 8'hA0, 2, 3, rd);
    rdchk(32'h102, 3, 0);
    host_u.qread(8'h00, 24'h200, 8'h00, 2, 2, rd);
    rdchk(32'h200, 2, 0);
    stchk("word cont off", 8, 3'h0);
    host_u.qread(OP_QUAD_READ, 24'h20, 8'hA0, 4, 1, rd);
    host_u.open_f();
    repeat (8) host_u.shift(4'hF, 4'hF, host_u.g);
    host_u.close_f();
    stchk("cont reset", 8, 3'h0);
  endtask
  task automatic s_wrap();
    int a;
    int len;
    for (int s = 0; s < 5; s++) begin
      len = (s < 4) ? 8 << s : 0;
      a = (s < 4) ? 32'h140 + len - 2 : 32'h146;
      host_u.open_f();
      host_u.tx_ser(OP_SET_WRAP);
      repeat (3) host_u.tx_ser(8'h00);
      host_u.tx_ser((s < 4) ? {1'b0, 2'(s), 5'h00} : 8'h10);
      host_u.close_f();
      stchk("wrap bits", 4, (s < 4) ? {2'(s), 1'b0} : 3'h1);
      host_u.qread(s[0] ? OP_QUAD_WORD_READ : OP_QUAD_READ, 24'(a), 8'h00, s[0] ? 2 : 4, 4, rd);
      rdchk(a, 4, len);
    end
  endtask
  task automatic s_prog();
    pp(24'h1FE, 1, 0);
    stchk("no latch", 0, 3'h0);
    ser(OP_WRITE_ENABLE);
    stchk("latch set", 0, 3'h2);
    host_u.open_f();
    host_u.tx_ser(OP_STATUS_LO);
    host_u.rx_ser(sb);
    host_u.close_f();
    chk("status low", 32'h2, {24'h0, sb});
    host_u.open_f();
    host_u.tx_ser(OP_STATUS_HI);
    host_u.rx_ser(sb);
    host_u.close_f();
    chk("status high", 32'h2, {24'h0, sb});
    pp(24'h1FE, 3, 0);
    stchk("busy", 0, 3'h1);
    snap = drive_cnt;
    host_u.qread(OP_QUAD_READ, 24'h0, 8'h00, 4, 1, rd);
    chk("busy read", snap, drive_cnt);
    wait_idle();
    for (int k = 0; k < 3; k++) mem[32'h100 + (32'hFE + k) % 256] = 8'(k) ^ 8'hC3;
    for (int k = 0; k < 4; k++) memchk(32'h1FE + k - ((k > 1) ? 256 : 0));
    ser(OP_WRITE_ENABLE);
    pp(24'h000, 1, 3);
    stchk("mid byte", 0, 3'h2);
    memchk(32'h0);
    avs(1'b1, REG_CTRL, 32'h0000_0101);
    ser(OP_WRITE_ENABLE);
    pp(24'h300, 1, 0);
    stchk("protected", 0, 3'h2);
    memchk(32'h300);
    avs(1'b1, REG_CTRL, 32'h1);
    pp(24'h200, 258, 0);
    wait_idle();
    for (int k = 0; k < 258; k++) mem[32'h200 + k % 256] = 8'(k) ^ 8'hC3;
    for (int k = 0; k < 4; k++) memchk(32'h200 + k * 85);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    s_reset();
    s_reads();
    s_wrap();
    s_prog();
    complete_run();
  end
endmodule
